// *** inc/sdsr_pkg.sv ***
// package: register map, field layout, reset values and state codes of the diagnostic bank
// What this block does
// - status bit 15 mirrors alert pin feedback
// - alert driven but pin high sets bit 14
// - serial out mismatch while driving sets bit 13
// - failed link check sets bit 12
// - wrong frame clock count sets bit 11
// - bits 10:8 report operating state code
// - over-voltage in active/standby sets bit 5
// - under-voltage in active/standby sets bit 4
// - per-source limit crossing flags in bits 3:0
// - read-only revision field at bits 5:4
// - bit 2 set disables link check
// - tally control: clear, fast, slow, stop
// - readback shows cycles counted since start
// - tally wraps at 16 bits, never saturates
// - bits 15:14 pick axis for gain
// - selected axis gain is value over 1024
// - summary code 2 when status flag set
package sdsr_pkg;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h0E;
    localparam logic [7:0] ADDR_TEST_CFG = 8'h0F;
    localparam logic [7:0] ADDR_OSC_READBACK = 8'h10;
    localparam logic [7:0] ADDR_GAIN_CFG = 8'h11;
    // fault flag fields
    localparam int unsigned BIT_ALERT_LEVEL = 15;
    localparam int unsigned BIT_ALERT_DRIVE = 14;
    localparam int unsigned BIT_SDO_DRIVE = 13;
    localparam int unsigned BIT_CHECK_FAIL = 12;
    localparam int unsigned BIT_FRAME_ERR = 11;
    localparam int unsigned OPSTATE_LSB = 8;
    localparam int unsigned BIT_OVER_V = 5;
    localparam int unsigned BIT_UNDER_V = 4;
    localparam logic [15:0] FLAGS_CLR_ON_READ = 16'h783F;
    // test config fields
    localparam int unsigned REV_LSB = 4;
    localparam int unsigned BIT_CHECK_DIS = 2;
    localparam logic [15:0] TEST_CFG_FIXED = 16'h0040;
    localparam logic [1:0] TALLY_CLEAR = 2'h0;
    localparam logic [1:0] TALLY_FAST = 2'h1;
    localparam logic [1:0] TALLY_SLOW = 2'h2;
    localparam logic [1:0] TALLY_STOP = 2'h3;
    // gain config fields
    localparam int unsigned GAIN_SEL_LSB = 14;
    localparam int unsigned GAIN_W = 11;
    localparam int unsigned GAIN_SHIFT = 10;
    localparam logic [15:0] GAIN_CFG_RESET = 16'h0000;
    localparam logic [1:0] AXIS_NONE = 2'h0;
    localparam logic [1:0] AXIS_X = 2'h1;
    localparam logic [1:0] AXIS_Y = 2'h2;
    localparam logic [1:0] AXIS_Z = 2'h3;
    localparam logic [1:0] SUMMARY_SYS = 2'h2;
    localparam logic [1:0] SUMMARY_AFE = 2'h1;
    typedef enum logic [2:0] {
        ST_CONFIG, ST_STANDBY, ST_CONTINUOUS, ST_TRIGGERED,
        ST_DUTY_ACTIVE, ST_DUTY_SLEEP, ST_SLEEP, ST_UNUSED
    } sdsr_opstate_t;
endpackage

// *** logic/sdsr_osc_tally.sv ***
// module: oscillator cycle tally driven by the tally control field
`timescale 1ns/1ps
`default_nettype none
module sdsr_osc_tally (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic [1:0] ctl_in, // tally control
    input wire logic fast_tick_in, // one pulse per fast oscillator cycle
    input wire logic slow_tick_in, // one pulse per slow oscillator cycle
    output logic [15:0] count_out // tally value
);
    logic [1:0] ctl_prev;
    logic [1:0] next_ctl_prev;
    logic [15:0] next_count;
    logic tick;

    always_comb
    begin
        next_ctl_prev = ctl_in;
        tick = 1'b0;
        next_count = count_out;
        unique case (ctl_in)
            sdsr_pkg::TALLY_CLEAR: next_count = 16'h0000;
            sdsr_pkg::TALLY_FAST: tick = fast_tick_in;
            sdsr_pkg::TALLY_SLOW: tick = slow_tick_in;
            sdsr_pkg::TALLY_STOP: tick = 1'b0;
        endcase
        // a fresh start restarts from zero so the value is cycles since start
        if (ctl_in != ctl_prev && (ctl_in == sdsr_pkg::TALLY_FAST || ctl_in == sdsr_pkg::TALLY_SLOW))
        begin
            next_count = {15'h0000, tick};
        end
        else if (tick)
        begin
            next_count = 16'(count_out + 16'h0001);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_out <= 16'h0000;
            ctl_prev <= sdsr_pkg::TALLY_CLEAR;
        end
        else if (ce_in)
        begin
            count_out <= next_count;
            ctl_prev <= next_ctl_prev;
        end
    end
endmodule // sdsr_osc_tally
`default_nettype wire

// *** logic/sdsr_gain_apply.sv ***
// module: scales one signed axis sample by gain/1024 with saturation
`timescale 1ns/1ps
`default_nettype none
module sdsr_gain_apply (
    input wire logic clk_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic ce_in, // clock enable
    input wire logic enable_in, // this axis is selected
    input wire logic [10:0] gain_in, // gain, 1024 is unity
    input wire logic signed [15:0] sample_in, // raw axis sample
    output logic signed [15:0] sample_out // corrected sample, registered
);
    logic signed [27:0] product;
    logic signed [17:0] scaled;
    logic signed [15:0] next_sample;

    always_comb
    begin
        // widen both operands first so the product never wraps inside the multiply
        product = 28'(sample_in) * 28'($signed({1'b0, gain_in}));
        scaled = 18'(product >>> sdsr_pkg::GAIN_SHIFT);
        // gain up to 2 can overflow 16 bits, so clamp instead of wrapping
        if (scaled > 18'sh07FFF)
        begin
            next_sample = 16'sh7FFF;
        end
        else if (scaled < -18'sh08000)
        begin
            next_sample = -16'sh8000;
        end
        else
        begin
            next_sample = scaled[15:0];
        end
        if (!enable_in)
        begin
            next_sample = sample_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sample_out <= 16'sh0000;
        end
        else if (ce_in)
        begin
            sample_out <= next_sample;
        end
    end
endmodule // sdsr_gain_apply
`default_nettype wire

// *** logic/sdsr_regs.sv ***
// module: fault flags, test configuration, oscillator readback and gain correction registers
`timescale 1ns/1ps
`default_nettype none
module sdsr_regs #(
    parameter logic [1:0] SILICON_REVISION = 2'h0 // arbitrary value, set per die
) (
    input wire logic CLK_IN, // 100 MHz system clock
    input wire logic RST_N_IN, // async reset, active low
    input wire logic CE_IN, // clock enable, freezes all state when low
    input wire logic REG_RD_IN, // register read strobe
    input wire logic REG_WR_IN, // register write strobe
    input wire logic [7:0] REG_ADDR_IN, // register address
    input wire logic [15:0] REG_WDATA_IN, // write data
    output logic [15:0] REG_RDATA_OUT, // read data
    output logic REG_RVALID_OUT, // read data valid pulse
    input wire logic ALERT_REQ_IN, // device wants alert asserted
    input wire logic ALERT_PIN_IN, // alert pin feedback
    output logic ALERT_OUT, // alert pin drive value (always low)
    output logic ALERT_OE_OUT, // alert pin drive enable
    input wire logic SDO_DRIVE_IN, // serial out being driven
    input wire logic SDO_VALUE_IN, // value driven on serial out
    input wire logic SDO_PIN_IN, // serial out pin feedback
    input wire logic CHECK_FAIL_IN, // link check failed, pulse
    input wire logic FRAME_ERR_IN, // bad frame clock count, pulse
    input wire logic [2:0] OPSTATE_IN, // present operating state
    input wire logic OVER_V_IN, // supply over-voltage detected
    input wire logic UNDER_V_IN, // supply under-voltage detected
    input wire logic [3:0] LIMIT_CROSS_IN, // temp, z, y, x limit crossings
    input wire logic AFE_FLAG_IN, // front end status has a flag set
    input wire logic FAST_OSC_TICK_IN, // fast oscillator cycle pulse
    input wire logic SLOW_OSC_TICK_IN, // slow oscillator cycle pulse
    input wire logic [15:0] X_IN, // raw x sample
    input wire logic [15:0] Y_IN, // raw y sample
    input wire logic [15:0] Z_IN, // raw z sample
    output logic [15:0] X_OUT, // gain-corrected x
    output logic [15:0] Y_OUT, // gain-corrected y
    output logic [15:0] Z_OUT, // gain-corrected z
    output logic LINK_CHECK_EN_OUT, // link check enabled
    output logic [1:0] ALERT_SUMMARY_OUT // alert source summary code
);
    // ==========================================================
    // state
    logic [15:0] flags;
    logic [15:0] next_flags;
    logic [2:0] opstate;
    logic [2:0] next_opstate;
    logic alert_level;
    logic next_alert_level;
    logic check_dis;
    logic next_check_dis;
    logic [1:0] tally_ctl;
    logic [1:0] next_tally_ctl;
    logic [15:0] gain_cfg;
    logic [15:0] next_gain_cfg;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic next_alert_oe;
    logic [1:0] next_summary;
    logic [15:0] tally;
    logic [15:0] raised;
    logic flag_rd;
    logic supply_watch;
    logic [15:0] test_cfg_view;
    logic [15:0] flags_view;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    // ==========================================================
    // fault and status flags
    always_comb
    begin
        supply_watch = (OPSTATE_IN == 3'(sdsr_pkg::ST_STANDBY))
            || (OPSTATE_IN == 3'(sdsr_pkg::ST_CONTINUOUS))
            || (OPSTATE_IN == 3'(sdsr_pkg::ST_TRIGGERED))
            || (OPSTATE_IN == 3'(sdsr_pkg::ST_DUTY_ACTIVE));
        raised = 16'h0000;
        // pin still high one cycle after drive began means the pull-down failed
        raised[sdsr_pkg::BIT_ALERT_DRIVE] = ALERT_OE_OUT & ALERT_PIN_IN;
        raised[sdsr_pkg::BIT_SDO_DRIVE] = SDO_DRIVE_IN & (SDO_VALUE_IN != SDO_PIN_IN);
        raised[sdsr_pkg::BIT_CHECK_FAIL] = CHECK_FAIL_IN & ~check_dis;
        raised[sdsr_pkg::BIT_FRAME_ERR] = FRAME_ERR_IN;
        raised[sdsr_pkg::BIT_OVER_V] = OVER_V_IN & supply_watch;
        raised[sdsr_pkg::BIT_UNDER_V] = UNDER_V_IN & supply_watch;
        raised[3:0] = LIMIT_CROSS_IN;
        flag_rd = REG_RD_IN && hit(REG_ADDR_IN, sdsr_pkg::ADDR_FAULT_FLAGS);
        next_flags = flags;
        if (flag_rd)
        begin
            next_flags = flags & ~sdsr_pkg::FLAGS_CLR_ON_READ;
        end
        // a new event in the read cycle survives the clear
        next_flags = (next_flags | raised) & sdsr_pkg::FLAGS_CLR_ON_READ;
        next_opstate = OPSTATE_IN;
        next_alert_level = ALERT_PIN_IN;
        next_alert_oe = ALERT_REQ_IN;
        next_summary = 2'h0;
        if (|flags)
        begin
            next_summary = next_summary | sdsr_pkg::SUMMARY_SYS;
        end
        if (AFE_FLAG_IN)
        begin
            next_summary = next_summary | sdsr_pkg::SUMMARY_AFE;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            flags <= 16'h0000;
            opstate <= 3'h0;
            alert_level <= 1'b0;
            ALERT_OE_OUT <= 1'b0;
            ALERT_OUT <= 1'b0;
            ALERT_SUMMARY_OUT <= 2'h0;
        end
        else if (CE_IN)
        begin
            flags <= next_flags;
            opstate <= next_opstate;
            alert_level <= next_alert_level;
            ALERT_OE_OUT <= next_alert_oe;
            ALERT_OUT <= 1'b0;
            ALERT_SUMMARY_OUT <= next_summary;
        end
    end

    // ==========================================================
    // configuration writes and read port
    always_comb
    begin
        flags_view = flags;
        flags_view[sdsr_pkg::BIT_ALERT_LEVEL] = alert_level;
        flags_view[10:8] = opstate;
        test_cfg_view = sdsr_pkg::TEST_CFG_FIXED;
        test_cfg_view[5:4] = SILICON_REVISION;
        test_cfg_view[sdsr_pkg::BIT_CHECK_DIS] = check_dis;
        test_cfg_view[1:0] = tally_ctl;
        next_check_dis = check_dis;
        next_tally_ctl = tally_ctl;
        next_gain_cfg = gain_cfg;
        // only writable fields are taken; revision and reserved bits are ignored
        if (REG_WR_IN && hit(REG_ADDR_IN, sdsr_pkg::ADDR_TEST_CFG))
        begin
            next_check_dis = REG_WDATA_IN[sdsr_pkg::BIT_CHECK_DIS];
            next_tally_ctl = REG_WDATA_IN[1:0];
        end
        if (REG_WR_IN && hit(REG_ADDR_IN, sdsr_pkg::ADDR_GAIN_CFG))
        begin
            next_gain_cfg = REG_WDATA_IN & 16'hC7FF;
        end
        next_rvalid = REG_RD_IN;
        next_rdata = 16'h0000;
        if (REG_RD_IN)
        begin
            unique case (REG_ADDR_IN)
                sdsr_pkg::ADDR_FAULT_FLAGS: next_rdata = flags_view;
                sdsr_pkg::ADDR_TEST_CFG: next_rdata = test_cfg_view;
                sdsr_pkg::ADDR_OSC_READBACK: next_rdata = tally;
                sdsr_pkg::ADDR_GAIN_CFG: next_rdata = gain_cfg;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            check_dis <= 1'b0;
            tally_ctl <= sdsr_pkg::TALLY_CLEAR;
            gain_cfg <= sdsr_pkg::GAIN_CFG_RESET;
            REG_RDATA_OUT <= 16'h0000;
            REG_RVALID_OUT <= 1'b0;
            LINK_CHECK_EN_OUT <= 1'b1;
        end
        else if (CE_IN)
        begin
            check_dis <= next_check_dis;
            tally_ctl <= next_tally_ctl;
            gain_cfg <= next_gain_cfg;
            REG_RDATA_OUT <= next_rdata;
            REG_RVALID_OUT <= next_rvalid;
            LINK_CHECK_EN_OUT <= ~next_check_dis;
        end
    end

    // ==========================================================
    // oscillator tally and gain correction
    sdsr_osc_tally u_tally (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .ctl_in(tally_ctl),
        .fast_tick_in(FAST_OSC_TICK_IN),
        .slow_tick_in(SLOW_OSC_TICK_IN),
        .count_out(tally)
    );

    sdsr_gain_apply u_gain_x (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .enable_in(gain_cfg[15:14] == sdsr_pkg::AXIS_X),
        .gain_in(gain_cfg[10:0]),
        .sample_in(X_IN),
        .sample_out(X_OUT)
    );

    sdsr_gain_apply u_gain_y (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .enable_in(gain_cfg[15:14] == sdsr_pkg::AXIS_Y),
        .gain_in(gain_cfg[10:0]),
        .sample_in(Y_IN),
        .sample_out(Y_OUT)
    );

    sdsr_gain_apply u_gain_z (
        .clk_in(CLK_IN),
        .rst_n_in(RST_N_IN),
        .ce_in(CE_IN),
        .enable_in(gain_cfg[15:14] == sdsr_pkg::AXIS_Z),
        .gain_in(gain_cfg[10:0]),
        .sample_in(Z_IN),
        .sample_out(Z_OUT)
    );

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_alert_level_mirror: assert property (CE_IN |=> alert_level == $past(ALERT_PIN_IN))
        else $error("alert level bit does not follow pin");
    a_alert_drive_fault: assert property (CE_IN && ALERT_OE_OUT && ALERT_PIN_IN
        |=> flags[sdsr_pkg::BIT_ALERT_DRIVE])
        else $error("alert drive fault not flagged");
    a_sdo_mismatch: assert property (CE_IN && SDO_DRIVE_IN && (SDO_VALUE_IN != SDO_PIN_IN)
        |=> flags[sdsr_pkg::BIT_SDO_DRIVE])
        else $error("serial out mismatch not flagged");
    a_check_fail_gate: assert property (CE_IN && CHECK_FAIL_IN && !check_dis
        |=> flags[sdsr_pkg::BIT_CHECK_FAIL])
        else $error("link check failure not flagged");
    a_check_disabled: assert property (CE_IN && check_dis && !flags[sdsr_pkg::BIT_CHECK_FAIL]
        |=> !flags[sdsr_pkg::BIT_CHECK_FAIL])
        else $error("check flag set while checking disabled");
    a_frame_err: assert property (CE_IN && FRAME_ERR_IN |=> flags[sdsr_pkg::BIT_FRAME_ERR])
        else $error("frame error not flagged");
    a_supply_gate: assert property (CE_IN && OVER_V_IN && !supply_watch && !flag_rd
        && !flags[sdsr_pkg::BIT_OVER_V] |=> !flags[sdsr_pkg::BIT_OVER_V])
        else $error("over-voltage flagged outside watch states");
    a_under_v: assert property (CE_IN && UNDER_V_IN && supply_watch
        |=> flags[sdsr_pkg::BIT_UNDER_V])
        else $error("under-voltage not flagged");
    a_limit_flags: assert property (CE_IN |=> (flags[3:0] & $past(LIMIT_CROSS_IN))
        == $past(LIMIT_CROSS_IN))
        else $error("limit crossing flag missing");
    a_read_clears: assert property (CE_IN && flag_rd && raised == 16'h0000
        |=> flags == 16'h0000 && REG_RVALID_OUT)
        else $error("clear-on-read did not clear");
    a_summary_code: assert property (CE_IN && (|flags) |=> ALERT_SUMMARY_OUT[1])
        else $error("summary misses status flag");
    a_tally_wrap: assert property (CE_IN && tally == 16'hFFFF && tally_ctl == $past(tally_ctl)
        && ((tally_ctl == sdsr_pkg::TALLY_FAST && FAST_OSC_TICK_IN)
        || (tally_ctl == sdsr_pkg::TALLY_SLOW && SLOW_OSC_TICK_IN))
        |=> tally == 16'h0000)
        else $error("tally did not wrap");
    a_tally_clear: assert property (CE_IN && tally_ctl == sdsr_pkg::TALLY_CLEAR
        |=> tally == 16'h0000)
        else $error("tally not cleared");
    a_revision_ro: assert property (CE_IN && REG_RD_IN && REG_ADDR_IN == sdsr_pkg::ADDR_TEST_CFG
        |=> REG_RVALID_OUT && REG_RDATA_OUT[5:4] == SILICON_REVISION)
        else $error("revision field wrong");
    a_gain_bypass: assert property (CE_IN && gain_cfg[15:14] == sdsr_pkg::AXIS_NONE
        |=> X_OUT == $past(X_IN))
        else $error("x corrected with no axis selected");

    c_flag_read: cover property (flag_rd && |flags);
    c_tally_run: cover property (tally_ctl == sdsr_pkg::TALLY_FAST && tally == 16'h0003);
    c_gain_x: cover property (gain_cfg[15:14] == sdsr_pkg::AXIS_X && gain_cfg[10:0] != 11'h400);
    c_set_wins: cover property (flag_rd && raised != 16'h0000);
endmodule // sdsr_regs
`default_nettype wire

// *** sim/sdsr_host_model.sv ***
// host-side model: issues register reads and writes on the strobe port
`timescale 1ns/1ps
`default_nettype none
module sdsr_host_model (
    input wire logic clk_in, // system clock
    input wire logic rvalid_in, // read data valid from the bank
    input wire logic [15:0] rdata_in, // read data from the bank
    output logic rd_out, // read strobe
    output logic wr_out, // write strobe
    output logic [7:0] addr_out, // register address
    output logic [15:0] wdata_out // write data
);
    // ==========================================
    // bus cycles, driven on the falling edge
    initial
    begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 8'hFF;
        wdata_out = 16'hFFFF;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
        @(negedge clk_in);
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = v;
        @(negedge clk_in);
        wr_out = 1'b0;
        addr_out = ~a; // a released bus must not keep showing the old value
        wdata_out = ~v;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        v = 'x;
        @(negedge clk_in);
        rd_out = 1'b1;
        addr_out = a;
        @(negedge clk_in);
        rd_out = 1'b0;
        addr_out = ~a;
        for (int i = 0; i < 3; i++)
        begin
            if (rvalid_in === 1'b1)
            begin
                v = rdata_in;
                break;
            end
            @(negedge clk_in);
        end
    endtask
endmodule // sdsr_host_model
`default_nettype wire

// *** sim/sdsr_regs_tb.sv ***
// self-checking bench for the diagnostic register bank
`timescale 1ns/1ps
`default_nettype none
module sdsr_regs_tb;
    localparam logic [1:0] REV = 2'h1; // arbitrary revision for the bench
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, stuck = 1'b0, serial_out_drive_fault = 1'b0, sdo_bad = 1'b0;
    logic sdo_val = 1'b0, cf = 1'b0, fe = 1'b0, ov = 1'b0, uv = 1'b0, afe = 1'b0;
    logic ft = 1'b0, st = 1'b0, ce = 1'b1, rd, wr, rvalid, oe, aout, en;
    logic [2:0] op = 3'h0;
    logic [3:0] lim = 4'h0;
    logic [1:0] summ;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, d;
    logic [15:0] xi[3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0] xo[3];
    int bad_count = 0, cmp_count = 0, fl = 0, r, g;
    wire logic pin = stuck | ~(oe & ~aout); // open-drain line with pull-up
    wire logic sdo_pin = (serial_out_drive_fault & ~sdo_bad) ? sdo_val : ~sdo_val; // undriven line drifts

    always #5 clk = ~clk;
    always @(negedge clk) sdo_val <= 1'($urandom);

    sdsr_regs #(.SILICON_REVISION(REV)) dut_u (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .REG_RD_IN(rd), .REG_WR_IN(wr),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
        .REG_RVALID_OUT(rvalid), .ALERT_REQ_IN(req), .ALERT_PIN_IN(pin), .ALERT_OUT(aout),
        .ALERT_OE_OUT(oe), .SDO_DRIVE_IN(serial_out_drive_fault), .SDO_VALUE_IN(sdo_val), .SDO_PIN_IN(sdo_pin),
        .CHECK_FAIL_IN(cf), .FRAME_ERR_IN(fe), .OPSTATE_IN(op), .OVER_V_IN(ov), .UNDER_V_IN(uv),
        .LIMIT_CROSS_IN(lim), .AFE_FLAG_IN(afe), .FAST_OSC_TICK_IN(ft), .SLOW_OSC_TICK_IN(st),
        .X_IN(xi[0]), .Y_IN(xi[1]), .Z_IN(xi[2]), .X_OUT(xo[0]), .Y_OUT(xo[1]), .Z_OUT(xo[2]),
        .LINK_CHECK_EN_OUT(en), .ALERT_SUMMARY_OUT(summ));

    sdsr_host_model host_u (.clk_in(clk), .rvalid_in(rvalid), .rdata_in(rdata), .rd_out(rd),
        .wr_out(wr), .addr_out(addr), .wdata_out(wdata));

    // ==========================================
    // checks and helpers
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // model flags are emptied once read back
    task automatic rd_flags(input logic p);
        logic [15:0] e;
        e = 16'(fl);
        e[15] = p;
        e[10:8] = op;
        host_u.rd_reg(8'h0E, d);
        chk_val(d, e);
        fl = 0;
    endtask

    task automatic ticks(input int n, input logic fast);
        repeat (n)
        begin
            @(negedge clk);
            ft = fast;
            st = ~fast;
        end
        @(negedge clk);
        ft = 1'b0;
        st = 1'b0;
    endtask

    function automatic logic [15:0] scaled(input logic [15:0] v, input int k);
        int p;
        p = ($signed(v) * k) >>> 10;
        if (p > 32767)
            p = 32767;
        if (p < -32768)
            p = -32768;
        return p[15:0];
    endfunction

    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #900000;
        bad_count++;
        stop_test();
    end

    // ==========================================
    // main sequence
    initial
    begin
        r = $urandom(83084);
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        host_u.rd_reg(8'h0F, d);
        chk_val(d, {10'h001, REV, 4'h0});
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'h0000);
        chk_bit(en, 1'b1);
        host_u.wr_reg(8'h0F, 16'hFFFF);
        host_u.rd_reg(8'h0F, d);
        chk_val(d, {10'h001, REV, 4'h7});
        chk_bit(en, 1'b0);
        cf = 1'b1;
        @(negedge clk);
        cf = 1'b0;
        rd_flags(1'b1);
        host_u.wr_reg(8'h0E, 16'hFFFF);
        host_u.wr_reg(8'h10, 16'hFFFF);
        host_u.wr_reg(8'h0F, 16'h0000);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'h0000);
        host_u.rd_reg(8'h3C, d);
        chk_val(d, 16'h0000);
        chk_bit(en, 1'b1);
        for (int i = 0; i < 14; i++)
        begin
            op = 3'(i % 7);
            r = $urandom;
            @(negedge clk);
            {cf, fe, ov, uv, lim} = r[7:0];
            fl = fl | {3'h0, r[7:6], 5'h0, (op inside {[1:4]}) ? r[5:4] : 2'b00, r[3:0]};
            @(negedge clk);
            {cf, fe, ov, uv, lim} = 8'h00;
            cyc(2);
            chk_bit(summ[1], 1'(fl != 0));
            rd_flags(1'b1);
            rd_flags(1'b1);
        end
        req = 1'b1;
        cyc(3);
        rd_flags(1'b0);
        stuck = 1'b1;
        cyc(2);
        req = 1'b0;
        stuck = 1'b0;
        fl = 16'h4000;
        cyc(2);
        chk_bit(summ[1], 1'b1);
        rd_flags(1'b1);
        rd_flags(1'b1);
        sdo_bad = 1'b1;
        cyc(2);
        serial_out_drive_fault = 1'b1;
        sdo_bad = 1'b0;
        cyc(3);
        rd_flags(1'b1);
        sdo_bad = 1'b1;
        @(negedge clk);
        serial_out_drive_fault = 1'b0;
        sdo_bad = 1'b0;
        fl = 16'h2000;
        cyc(2);
        rd_flags(1'b1);
        afe = 1'b1;
        cyc(2);
        chk_bit(summ[0], 1'b1);
        afe = 1'b0;
        cyc(2);
        chk_bit(summ[0], 1'b0);
        host_u.wr_reg(8'h0F, 16'h0001);
        ticks(300, 1'b1);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'd300);
        host_u.wr_reg(8'h0F, 16'h0003);
        ticks(50, 1'b1);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'd300);
        host_u.wr_reg(8'h0F, 16'h0000);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'h0000);
        host_u.wr_reg(8'h0F, 16'h0002);
        ticks(40, 1'b1);
        ticks(70, 1'b0);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'd70);
        host_u.wr_reg(8'h0F, 16'h0001);
        ticks(65545, 1'b1);
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'd9);
        // ticks while the enable is low must not reach the tally
        ce = 1'b0;
        ticks(20, 1'b1);
        ce = 1'b1;
        host_u.rd_reg(8'h10, d);
        chk_val(d, 16'd9);
        for (int a = 0; a < 4; a++)
            for (int k = 0; k < 3; k++)
            begin
                g = (k == 0) ? 2047 : $urandom % 2048;
                host_u.wr_reg(8'h11, {a[1:0], 3'h7, g[10:0]});
                host_u.rd_reg(8'h11, d);
                chk_val(d, {a[1:0], 3'h0, g[10:0]});
                foreach (xi[j])
                    xi[j] = 16'($urandom);
                @(negedge clk);
                foreach (xo[j])
                    chk_val(xo[j], (a == j + 1) ? scaled(xi[j], g) : xi[j]);
            end
        // mid-run reset must bring configuration back to defaults
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        host_u.rd_reg(8'h0F, d);
        chk_val(d, {10'h001, REV, 4'h0});
        host_u.rd_reg(8'h11, d);
        chk_val(d, 16'h0000);
        chk_bit(en, 1'b1);
        stop_test();
    end
endmodule // sdsr_regs_tb
`default_nettype wire
